// ===== inc/xid_pkg.sv
// shared constants and carrier types for the exchange decoder
`default_nettype none
package xid_pkg;
	// ****************************************
	// opcode fields and reset values
	// ****************************************
	localparam logic [7:0] ESC_PREFIX = 8'ha5;
	localparam logic [3:0] OP_HI_SWAP_REG = 4'hc;
	localparam int SEL_BIT = 3;
	localparam logic [3:0] OP_HI_SWAP_DIGIT = 4'hd;
	localparam logic [2:0] OP_LO_DIGIT_BASE = 3'h3;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] BANK_RESET = 2'h0;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} xid_byte_s;

	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} xid_ram_wr_s;
endpackage : xid_pkg
`default_nettype wire

// ===== hw/xid_opcode_match.sv
// classifies one opcode byte as a register swap or a digit swap
`timescale 1ns/1ns
`default_nettype none
module xid_opcode_match
(
	// opcode in
	input wire logic [7:0] opcode_i,
	// classification out
	output logic is_reg_o,
	output logic is_digit_o,
	output logic [2:0] sel_o
);
	always_comb
	begin
		is_reg_o = (opcode_i[7:4] == xid_pkg::OP_HI_SWAP_REG) && opcode_i[xid_pkg::SEL_BIT];
		// digit swap uses 1101 011i, only pointers 0 and 1 exist
		is_digit_o = (opcode_i[7:4] == xid_pkg::OP_HI_SWAP_DIGIT)
			&& (opcode_i[3:1] == xid_pkg::OP_LO_DIGIT_BASE);
		sel_o = opcode_i[2:0];
		// the digit swap names its pointer by bit 0 alone
		if (is_digit_o)
		begin
			sel_o = {2'h0, opcode_i[0]};
		end
	end
endmodule : xid_opcode_match
`default_nettype wire

// ===== hw/xid_exchange_decode.sv
// decode and execute of the two exchange instructions
`timescale 1ns/1ns
`default_nettype none
module xid_exchange_decode
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// mode and bank
	input wire logic source_mode_i,
	input wire logic [1:0] bank_i,
	// fetched bytes
	input wire xid_pkg::xid_byte_s fetch_i,
	// ram read port, combinational
	output logic [7:0] ram_raddr_o,
	input wire logic [7:0] ram_rdata_i,
	// ram write port
	output xid_pkg::xid_ram_wr_s ram_wr_o,
	// state and completion
	output logic [7:0] acc_o,
	output logic done_o,
	output logic [4:0] reg_sel_o,
	output logic [7:0] reg_data_o,
	output logic [7:0] reg_dbg_o
);
	// ****************************************
	// state
	// ****************************************
	logic [7:0] regs_r [0:31];
	logic [7:0] regs_nxt [0:31];
	logic [7:0] acc_r, acc_nxt;
	logic esc_r, esc_nxt;
	xid_pkg::xid_ram_wr_s wr_r, wr_nxt;
	logic done_r, done_nxt;
	logic is_reg, is_digit;
	logic [2:0] sel;
	logic armed;
	logic [4:0] idx;
	logic [7:0] ptr;

	xid_opcode_match u_match
	(
		.opcode_i(fetch_i.data),
		.is_reg_o(is_reg),
		.is_digit_o(is_digit),
		.sel_o(sel)
	);

	// ****************************************
	// decode
	// ****************************************
	// only the byte right after the prefix is an exchange in source mode
	assign armed = fetch_i.valid && (source_mode_i ? esc_r : 1'b1);
	assign idx = {bank_i, sel};
	assign ptr = regs_r[idx];
	assign ram_raddr_o = ptr;

	always_comb
	begin
		regs_nxt = regs_r;
		acc_nxt = acc_r;
		wr_nxt = '0;
		done_nxt = 1'b0;
		esc_nxt = esc_r;
		if (fetch_i.valid)
		begin
			// any other byte clears the prefix; a repeated prefix stays armed
			esc_nxt = source_mode_i && (fetch_i.data == xid_pkg::ESC_PREFIX);
		end
		if (armed && is_reg)
		begin
			acc_nxt = regs_r[idx];
			regs_nxt[idx] = acc_r;
			done_nxt = 1'b1;
		end
		else if (armed && is_digit)
		begin
			acc_nxt = {acc_r[7:4], ram_rdata_i[3:0]};
			wr_nxt.we = 1'b1;
			wr_nxt.addr = ptr;
			wr_nxt.data = {ram_rdata_i[7:4], acc_r[3:0]};
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < 32; i++)
			begin
				regs_r[i] <= xid_pkg::REG_RESET;
			end
			acc_r <= xid_pkg::ACC_RESET;
			esc_r <= 1'b0;
			wr_r <= '0;
			done_r <= 1'b0;
		end
		else
		begin
			regs_r <= regs_nxt;
			acc_r <= acc_nxt;
			esc_r <= esc_nxt;
			wr_r <= wr_nxt;
			done_r <= done_nxt;
		end
	end

	assign acc_o = acc_r;
	assign ram_wr_o = wr_r;
	assign done_o = done_r;
	assign reg_sel_o = idx;
	assign reg_data_o = regs_r[idx];
	assign reg_dbg_o = regs_r[5'h00];

	// ****************************************
	// checks
	// ****************************************
	sequence s_reg_swap;
		armed && is_reg;
	endsequence

	property p_reg_to_acc;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_reg_swap |=> (acc_r == $past(regs_r[idx])) && done_r;
	endproperty
	a_reg_to_acc: assert property (p_reg_to_acc) else $error("acc not loaded from register");

	property p_acc_to_reg;
		@(posedge clk_i) disable iff (!rst_n_i)
		s_reg_swap |=> (regs_r[$past(idx)] == $past(acc_r));
	endproperty
	a_acc_to_reg: assert property (p_acc_to_reg) else $error("register not loaded from acc");

	property p_binary_direct;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!source_mode_i && fetch_i.valid && (is_reg || is_digit)) |=> done_r;
	endproperty
	a_binary_direct: assert property (p_binary_direct) else $error("binary opcode ignored");

	property p_source_needs_prefix;
		@(posedge clk_i) disable iff (!rst_n_i)
		(source_mode_i && fetch_i.valid && !esc_r) |=> !done_r;
	endproperty
	a_source_needs_prefix: assert property (p_source_needs_prefix) else $error("no prefix exec");

	property p_source_pair;
		@(posedge clk_i) disable iff (!rst_n_i)
		(source_mode_i && fetch_i.valid && fetch_i.data == xid_pkg::ESC_PREFIX)
		##1 (source_mode_i && fetch_i.valid && is_reg) |=> done_r;
	endproperty
	a_source_pair: assert property (p_source_pair) else $error("prefixed swap ignored");

	property p_digit_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		(armed && is_digit) |=> (acc_r[3:0] == $past(ram_rdata_i[3:0]))
			&& (ram_wr_o.data[3:0] == $past(acc_r[3:0]));
	endproperty
	a_digit_low: assert property (p_digit_low) else $error("low digit not swapped");

	property p_digit_high;
		@(posedge clk_i) disable iff (!rst_n_i)
		(armed && is_digit) |=> (acc_r[7:4] == $past(acc_r[7:4]))
			&& (ram_wr_o.data[7:4] == $past(ram_rdata_i[7:4]));
	endproperty
	a_digit_high: assert property (p_digit_high) else $error("high digit changed");

	property p_digit_addr;
		@(posedge clk_i) disable iff (!rst_n_i)
		(armed && is_digit) |=> ram_wr_o.we && (ram_wr_o.addr == $past(regs_r[idx]));
	endproperty
	a_digit_addr: assert property (p_digit_addr) else $error("wrong digit address");

	property p_bank_index;
		@(posedge clk_i) disable iff (!rst_n_i)
		!is_digit |-> (reg_sel_o == {bank_i, fetch_i.data[2:0]});
	endproperty
	a_bank_index: assert property (p_bank_index) else $error("bad bank index");

	property p_digit_pointer;
		@(posedge clk_i) disable iff (!rst_n_i)
		is_digit |-> (reg_sel_o == {bank_i, 2'h0, fetch_i.data[0]});
	endproperty
	a_digit_pointer: assert property (p_digit_pointer) else $error("wrong pointer register");

	// a stray strobe would corrupt a ram byte behind the core's back
	property p_digit_we_only;
		@(posedge clk_i) disable iff (!rst_n_i)
		!(armed && is_digit) |=> !ram_wr_o.we;
	endproperty
	a_digit_we_only: assert property (p_digit_we_only) else $error("stray ram write");
endmodule : xid_exchange_decode
`default_nettype wire

// ===== dv/xid_ram_model.sv
// behavioural on-chip data ram seen by the exchange decoder
`timescale 1ns/1ns
`default_nettype none
module xid_ram_model
(
	// clock
	input wire logic clk_i,
	// read port, combinational
	input wire logic [7:0] raddr_i,
	output logic [7:0] rdata_o,
	// write port
	input wire xid_pkg::xid_ram_wr_s wr_i
);
	logic [7:0] mem [256];
	// preload a+37 so addresses 0 to 8 differ from the reset zeros in both nibbles
	initial for (int a = 0; a < 256; a++) mem[a] = 8'(a + 8'h37);
	assign rdata_o = mem[raddr_i];
	always @(posedge clk_i) if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
endmodule : xid_ram_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the exchange decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 0;
	logic rst_n = 0;
	logic src = 0;
	logic [1:0] bank = 2'h0;
	xid_pkg::xid_byte_s fet = '0;
	logic [7:0] raddr, rdata, acc, rdat, dbg;
	logic [4:0] rsel;
	logic done;
	xid_pkg::xid_ram_wr_s wr;
	int failures = 0;
	int n_checks = 0;
	xid_exchange_decode xid_exchange_decode_i (.clk_i(clk), .rst_n_i(rst_n),
		.source_mode_i(src), .bank_i(bank), .fetch_i(fet), .ram_raddr_o(raddr),
		.ram_rdata_i(rdata), .ram_wr_o(wr), .acc_o(acc), .done_o(done),
		.reg_sel_o(rsel), .reg_data_o(rdat), .reg_dbg_o(dbg));
	xid_ram_model xid_ram_model_i (.clk_i(clk), .raddr_i(raddr), .rdata_o(rdata),
		.wr_i(wr));
	initial forever #50 clk = ~clk;
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask : chk
	// one valid byte; returns in the cycle where results stand
	task send(input logic [7:0] b);
		@(posedge clk);
		#10 fet = {1'b1, b};
		@(posedge clk);
		#10 fet.valid = 1'b0;
	endtask : send
	// prefix and opcode on consecutive edges, valid held high between them
	task send_pair(input logic [7:0] p, input logic [7:0] b);
		@(posedge clk);
		#10 fet = {1'b1, p};
		@(posedge clk);
		#10 fet = {1'b1, b};
		@(posedge clk);
		#10 fet.valid = 1'b0;
	endtask : send_pair
	task summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	// ****
	// scenarios
	// ****
	task t_digit;
		send(8'hd6);
		chk(acc, 8'h07);
		chk(wr.addr, 8'h00);
		chk({3'h0, rsel}, 8'h00);
		chk({7'h00, wr.we}, 8'h01);
		chk(wr.data, 8'h30);
		chk({7'h00, done}, 8'h01);
	endtask : t_digit
	task t_reg;
		send(8'hc9);
		chk(acc, 8'h00);
		chk(rdat, 8'h07);
		chk({7'h00, wr.we}, 8'h00);
		send(8'hc9);
		send(8'hc8);
		chk(dbg, 8'h07);
		send(8'hd6);
		chk(wr.addr, 8'h07);
		chk(wr.data, 8'h30);
		chk(acc, 8'h0e);
	endtask : t_reg
	task t_bank;
		bank = 2'h1;
		send(8'hc8);
		chk(acc, 8'h00);
		chk(rdat, 8'h0e);
		chk({3'h0, rsel}, 8'h08);
		chk(dbg, 8'h07);
	endtask : t_bank
	task t_source;
		src = 1'b1;
		send(8'hc8);
		chk({7'h00, done}, 8'h00);
		send(8'ha5);
		send(8'h00);
		send(8'hc8);
		chk(acc, 8'h00);
		send(8'ha5);
		send(8'hc8);
		chk({7'h00, done}, 8'h01);
		chk(acc, 8'h0e);
		send(8'ha5);
		send(8'hd7);
		chk(wr.addr, 8'h00);
		chk({3'h0, rsel}, 8'h09);
		chk(wr.data, 8'h3e);
		chk(acc, 8'h00);
		bank = 2'h0;
		send_pair(8'ha5, 8'hc8);
		chk({7'h00, done}, 8'h01);
		chk(acc, 8'h07);
		chk(dbg, 8'h00);
	endtask : t_source
	initial
	begin
		repeat (2) @(posedge clk);
		#10 rst_n = 1'b1;
		t_digit();
		t_reg();
		t_bank();
		t_source();
		summarize();
	end
	// whole run is under 60 cycles
	initial
	begin
		#100000;
		failures++;
		summarize();
	end
endmodule : tb
`default_nettype wire
